// *** hdl/cwdt_defs.svh ***
`ifndef CWDT_DEFS_SVH
`define CWDT_DEFS_SVH

// Byte addresses of the registers on the AXI4-Lite port.
`define CWDT_ADDR_W 8
`define CWDT_OFF_CTRL 8'h00
`define CWDT_OFF_SERVICE 8'h04
`define CWDT_OFF_IRQ_STAT 8'h08
`define CWDT_OFF_IRQ_CLR 8'h0C
`define CWDT_OFF_IRQ_EN 8'h10
`define CWDT_OFF_COUNT 8'h14

// Control register field positions.
`define CWDT_BIT_ENABLE 7
`define CWDT_BIT_SELECT 6
`define CWDT_BIT_TERM_EN 2
`define CWDT_BIT_TERM_FLAG 1
`define CWDT_BIT_IRQ_FLAG 0
`define CWDT_CTRL_RESET 8'h00

// Service unlock pattern.
`define CWDT_SVC_FIRST 8'h55
`define CWDT_SVC_SECOND 8'hAA

// Time-out exponents for period codes 7 down to 0, five bits each.
`define CWDT_PERIOD_EXPS 40'hFEEF37B569

// Interrupt status bit positions.
`define CWDT_EV_TIMEOUT 0
`define CWDT_EV_TERM 1
`define CWDT_EV_N 2

`define CWDT_RESP_OKAY 2'h0
`define CWDT_RESP_SLVERR 2'h2

`endif

// *** hdl/cwdt_pkg.sv ***
package cwdt_pkg;

  typedef struct packed {
    logic wd_enable_bit;
    logic timeout_action_select;
    logic [2:0] timeout_period_field;
    logic bus_terminate_enable;
    logic bus_terminate_occurred;
    logic timeout_irq_flag;
  } cwdt_ctrl_s;

  // Gray-coded along run -> first expiry -> acknowledged -> terminated.
  typedef enum logic [1:0] {
    CWDT_RUN = 2'h0,
    CWDT_FIRST = 2'h1,
    CWDT_ACKED = 2'h3,
    CWDT_TERMED = 2'h2
  } cwdt_stage_e;

  typedef enum logic {
    CWDT_SVC_IDLE = 1'b0,
    CWDT_SVC_ARMED = 1'b1
  } cwdt_svc_e;

  typedef logic [31:0] cwdt_count_t;

endpackage

// *** hdl/cwdt_top.sv ***
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "cwdt_defs.svh"
// Overview of operation
// - Watchdog counts only while enable bit 7 is set; disabled after reset.
// - Unserviced enabled watchdog times out and raises interrupt request to the core.
// - Select bit 6 at 0 sends time-out to interrupt; 1 is reserved.
// - With terminate enabled, second unacknowledged time-out pulses transfer acknowledge.
// - Own transfer acknowledge sets the terminate-occurred flag.
// - Other activity between the two service writes does not break servicing.
// - Count is compared against the current period field every cycle.
// - Control register always readable; while time-out pending, writes only clear the flags.
// - Reset clears the period field to shortest time-out, watchdog disabled.
// - Period codes 000, 001, 010 select 2^9, 2^11, 2^13 clocks.
// - Codes 011 to 111 select 2^15, 2^19, 2^23, 2^27, 2^31 clocks.
// - Terminate flag and interrupt flag clear only by writing 1.
// - Service writes after a time-out never withdraw the interrupt.
module cwdt_top
  import cwdt_pkg::*;
#(
  parameter logic [39:0] PERIOD_EXPS = `CWDT_PERIOD_EXPS
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic IRQ_ACK,
  output logic WD_IRQ_REQ,
  output logic TRANSFER_ACKNOWLEDGE,
  output logic IRQ
);

  // Bus write and read sides.
  logic aw_hold_r, w_hold_r, bvalid_r, awready_r, wready_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  cwdt_ctrl_s ctrl_r;
  cwdt_stage_e stage_r, stage_nxt;
  cwdt_svc_e svc_r, svc_nxt;
  cwdt_count_t cnt_r, cnt_nxt;
  logic [`CWDT_EV_N-1:0] stat_r, stat_nxt, irq_en_r;
  logic ta_r, irq_r;

  wire aw_take = S_AXI_AWVALID & awready_r;
  wire w_take = S_AXI_WVALID & wready_r;
  wire wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  wire ar_take = S_AXI_ARVALID & arready_r;
  wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
  wire w_hold_nxt = (w_hold_r | w_take) & ~wr_do;
  wire bvalid_nxt = wr_do | (bvalid_r & ~S_AXI_BREADY);
  wire rvalid_nxt = ar_take | (rvalid_r & ~S_AXI_RREADY);

  wire wr_ctrl = wr_do & (awaddr_r == `CWDT_OFF_CTRL) & wstrb_r[0];
  wire wr_svc = wr_do & (awaddr_r == `CWDT_OFF_SERVICE) & wstrb_r[0];
  wire wr_clr = wr_do & (awaddr_r == `CWDT_OFF_IRQ_CLR) & wstrb_r[0];
  wire wr_en = wr_do & (awaddr_r == `CWDT_OFF_IRQ_EN) & wstrb_r[0];
  wire wr_hit = (awaddr_r == `CWDT_OFF_CTRL) | (awaddr_r == `CWDT_OFF_SERVICE) |
                (awaddr_r == `CWDT_OFF_IRQ_CLR) | (awaddr_r == `CWDT_OFF_IRQ_EN);
  wire [7:0] wbyte = wdata_r[7:0];

  // Service unlock: stray values leave the armed state alone so that
  // unrelated accesses between the two writes do not break servicing.
  wire svc_first = wr_svc & (wbyte == `CWDT_SVC_FIRST);
  wire svc_done = wr_svc & (wbyte == `CWDT_SVC_SECOND) & (svc_r == CWDT_SVC_ARMED);
  assign svc_nxt = svc_done ? CWDT_SVC_IDLE :
                   svc_first ? CWDT_SVC_ARMED : svc_r;

  // Period lookup is live, so a new period field is used on the next compare.
  wire [4:0] period_exp = PERIOD_EXPS[5*ctrl_r.timeout_period_field +: 5];
  wire cwdt_count_t period_last = (cwdt_count_t'(1) << period_exp) - cwdt_count_t'(1);
  wire running = ctrl_r.wd_enable_bit;
  wire expire = running & (cnt_r >= period_last);
  assign cnt_nxt = (svc_done | expire) ? '0 :
                   running ? cnt_r + cwdt_count_t'(1) : cnt_r;

  wire pending = (stage_r != CWDT_RUN);
  wire first_to = expire & (stage_r == CWDT_RUN);
  wire term_fire = expire & (stage_r == CWDT_FIRST) & ~IRQ_ACK &
                   ctrl_r.bus_terminate_enable;
  wire irq_clr = wr_ctrl & wbyte[`CWDT_BIT_IRQ_FLAG];
  wire term_clr = wr_ctrl & wbyte[`CWDT_BIT_TERM_FLAG];

  // The stage returns to run only once the flag is really cleared, so a
  // service write after the time-out cannot withdraw the request.
  always_comb begin
    stage_nxt = stage_r;
    case (stage_r)
      CWDT_RUN: if (first_to) stage_nxt = CWDT_FIRST;
      CWDT_FIRST: begin
        if (irq_clr) stage_nxt = CWDT_RUN;
        else if (IRQ_ACK) stage_nxt = CWDT_ACKED;
        else if (term_fire) stage_nxt = CWDT_TERMED;
      end
      CWDT_ACKED, CWDT_TERMED: if (irq_clr) stage_nxt = CWDT_RUN;
      default: stage_nxt = CWDT_RUN;
    endcase
  end

  wire [`CWDT_EV_N-1:0] ev_set = {term_fire, first_to};
  assign stat_nxt = (stat_r & ~(wr_clr ? wbyte[`CWDT_EV_N-1:0] : '0)) | ev_set;

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  wire irq_flag_nxt = first_to | (ctrl_r.timeout_irq_flag & ~irq_clr);
  wire term_flag_nxt = term_fire | (ctrl_r.bus_terminate_occurred & ~term_clr);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_r <= cwdt_ctrl_s'(`CWDT_CTRL_RESET);
    end else begin
      ctrl_r.timeout_irq_flag <= irq_flag_nxt;
      ctrl_r.bus_terminate_occurred <= term_flag_nxt;
      if (wr_ctrl && !pending) begin
        ctrl_r.wd_enable_bit <= wbyte[`CWDT_BIT_ENABLE];
        // Time-outs can only be routed to the interrupt; the reserved setting is kept 0.
        ctrl_r.timeout_action_select <= 1'b0;
        ctrl_r.timeout_period_field <= wbyte[5:3];
        ctrl_r.bus_terminate_enable <= wbyte[`CWDT_BIT_TERM_EN];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stage_r <= CWDT_RUN;
      svc_r <= CWDT_SVC_IDLE;
      cnt_r <= '0;
      stat_r <= '0;
      irq_en_r <= '0;
      ta_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      svc_r <= svc_nxt;
      cnt_r <= cnt_nxt;
      stat_r <= stat_nxt;
      if (wr_en) irq_en_r <= wbyte[`CWDT_EV_N-1:0];
      ta_r <= term_fire;
      irq_r <= |(stat_nxt & irq_en_r);
    end
  end

  // Bus handshake registers.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r <= ~w_hold_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  wire [31:0] rd_mux =
    (S_AXI_ARADDR == `CWDT_OFF_CTRL) ? {24'h000000, ctrl_r} :
    (S_AXI_ARADDR == `CWDT_OFF_IRQ_STAT) ? {30'h0000000, stat_r} :
    (S_AXI_ARADDR == `CWDT_OFF_IRQ_EN) ? {30'h0000000, irq_en_r} :
    (S_AXI_ARADDR == `CWDT_OFF_COUNT) ? cnt_r : 32'h00000000;
  wire rd_hit = (S_AXI_ARADDR == `CWDT_OFF_CTRL) | (S_AXI_ARADDR == `CWDT_OFF_IRQ_STAT) |
                (S_AXI_ARADDR == `CWDT_OFF_IRQ_EN) | (S_AXI_ARADDR == `CWDT_OFF_COUNT) |
                (S_AXI_ARADDR == `CWDT_OFF_SERVICE) | (S_AXI_ARADDR == `CWDT_OFF_IRQ_CLR);

  always_ff @(posedge SYS_CLK) begin
    if (aw_take) awaddr_r <= S_AXI_AWADDR;
    if (w_take) wdata_r <= S_AXI_WDATA;
    if (w_take) wstrb_r <= S_AXI_WSTRB;
    if (!RST_N) bresp_r <= `CWDT_RESP_OKAY;
    else if (wr_do) bresp_r <= wr_hit ? `CWDT_RESP_OKAY : `CWDT_RESP_SLVERR;
    if (!RST_N) rdata_r <= 32'h00000000;
    else if (ar_take) rdata_r <= rd_mux;
    if (!RST_N) rresp_r <= `CWDT_RESP_OKAY;
    else if (ar_take) rresp_r <= rd_hit ? `CWDT_RESP_OKAY : `CWDT_RESP_SLVERR;
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign WD_IRQ_REQ = ctrl_r.timeout_irq_flag;
  assign TRANSFER_ACKNOWLEDGE = ta_r;
  assign IRQ = irq_r;

  a_disabled_frozen: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !ctrl_r.wd_enable_bit && !svc_done |=> $stable(cnt_r))
    else $error("Count moved while disabled.");
  a_timeout_raises: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    first_to |=> WD_IRQ_REQ && cnt_r == 32'h00000000)
    else $error("Time-out did not raise the request.");
  a_select_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ##1 !ctrl_r.timeout_action_select)
    else $error("Reserved select bit became set.");
  a_term_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    term_fire |=> TRANSFER_ACKNOWLEDGE ##1 !TRANSFER_ACKNOWLEDGE)
    else $error("Transfer acknowledge not a single pulse.");
  a_term_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    TRANSFER_ACKNOWLEDGE |-> ctrl_r.bus_terminate_occurred)
    else $error("Terminate flag missing after acknowledge.");
  a_service_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    svc_done |=> cnt_r == 32'h00000000 && svc_r == CWDT_SVC_IDLE)
    else $error("Service pair did not restart the count.");
  a_pending_locked: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pending && wr_ctrl |=> $stable(ctrl_r.timeout_period_field) &&
    $stable(ctrl_r.wd_enable_bit))
    else $error("Control changed while pending.");
  a_irq_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    WD_IRQ_REQ && !irq_clr |=> WD_IRQ_REQ)
    else $error("Request dropped without a flag clear.");
  a_no_lone_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    wr_svc && wbyte != `CWDT_SVC_SECOND && running && !expire |=> cnt_r == $past(cnt_r) + 1)
    else $error("Count restarted without the pair.");

  // Reset, counting and servicing behaviour.
  a_reset_clear: assert property (@(posedge SYS_CLK)
    !RST_N |=> !ctrl_r.wd_enable_bit && ctrl_r.timeout_period_field == 3'h0)
    else $error("Control not cleared by reset.");
  a_enable_counts: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ctrl_r.wd_enable_bit && !svc_done && !expire |=> cnt_r == $past(cnt_r) + 1)
    else $error("Count stalled while enabled.");
  a_expire_wraps: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    expire |=> cnt_r == 32'h00000000)
    else $error("Count not restarted at expiry.");
  a_disabled_no_irq: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !ctrl_r.wd_enable_bit && !WD_IRQ_REQ |=> !WD_IRQ_REQ)
    else $error("Request raised while disabled.");
  a_irq_from_expiry: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(WD_IRQ_REQ) |-> $past(expire))
    else $error("Request raised without an expiry.");
  a_period_applied: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !pending && wr_ctrl |=> ctrl_r.timeout_period_field == $past(wbyte[5:3]))
    else $error("Control write not applied while idle.");
  a_armed_kept: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    svc_r == CWDT_SVC_ARMED && wr_svc && wbyte != `CWDT_SVC_FIRST &&
    wbyte != `CWDT_SVC_SECOND |=> svc_r == CWDT_SVC_ARMED)
    else $error("Stray service write broke the pair.");

  // Termination and sticky flag behaviour.
  a_ta_needs_enable: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    TRANSFER_ACKNOWLEDGE |-> $past(ctrl_r.bus_terminate_enable) && $past(expire))
    else $error("Acknowledge without enable or expiry.");
  a_ack_blocks_ta: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ_ACK |=> !TRANSFER_ACKNOWLEDGE)
    else $error("Acknowledge followed an interrupt acknowledge.");
  a_term_sets_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    term_fire |=> ctrl_r.bus_terminate_occurred && stat_r[`CWDT_EV_TERM])
    else $error("Termination flags not set.");
  a_irq_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $fell(WD_IRQ_REQ) |-> $past(irq_clr))
    else $error("Interrupt flag fell without a clear.");
  a_term_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $fell(ctrl_r.bus_terminate_occurred) |-> $past(term_clr))
    else $error("Terminate flag fell without a clear.");
  a_irq_line_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (|(stat_r & irq_en_r)) && $stable(irq_en_r) |-> IRQ)
    else $error("Interrupt line low with an enabled event.");

  // Bus handshake outputs.
  a_bvalid_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped early.");
  a_rvalid_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read response dropped early.");
  a_write_refused: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("Write channel ready while response pending.");
  a_read_refused: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("Read address ready while data pending.");

endmodule
`default_nettype wire

// *** bench/cwdt_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cwdt_defs.svh"
module tb;
  // Exponents 5 to 12 keep every period short yet distinct per code.
  function automatic logic [39:0] mk_exps();
    for (int i = 0; i < 8; i++) mk_exps[5*i+:5] = 5'(5 + i);
  endfunction
  localparam logic [39:0] EXPS = mk_exps();
  localparam logic [7:0] CT = `CWDT_OFF_CTRL;
  localparam logic [7:0] SV = `CWDT_OFF_SERVICE;
  localparam logic [7:0] ST = `CWDT_OFF_IRQ_STAT;
  localparam logic [7:0] CL = `CWDT_OFF_IRQ_CLR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, ack = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic awr, wrd, bv, arr, rv, wdirq, ta, irq;
  logic [1:0] br, rr;
  logic [33:0] exq[$];
  int err_total = 0, samples_checked = 0, cyc = 0, seed = 58, n, p;
  always #5 clk = ~clk;
  cwdt_top #(.PERIOD_EXPS(EXPS)) uut (
    .SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .IRQ_ACK(ack), .WD_IRQ_REQ(wdirq),
    .TRANSFER_ACKNOWLEDGE(ta), .IRQ(irq));
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) fail(m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    bit got_a;
    bit got_w;
    int rnd;
    got_a = 1'b0;
    got_w = 1'b0;
    rnd = $random(seed);
    exq.push_back({r, 32'h0});
    @(posedge clk);
    awa <= a;
    wd <= {rnd[31:8], d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(got_a && got_w)) begin
      @(posedge clk);
      if (awv && awr === 1'b1) begin
        got_a = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrd === 1'b1) begin
        got_w = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    bre <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    exq.push_back({r, e});
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rre <= 1'b0;
  endtask
  // Any stray write between the two halves must leave the pair intact.
  task automatic svc(input bit junk);
    logic [7:0] j;
    j = 8'($random(seed));
    if (j == `CWDT_SVC_FIRST || j == `CWDT_SVC_SECOND) j = 8'h00;
    wr(SV, `CWDT_SVC_FIRST);
    if (junk) wr(SV, j);
    wr(SV, `CWDT_SVC_SECOND);
  endtask
  task automatic wait_for(input bit on_ta, input int lim, output int k);
    k = 0;
    while ((on_ta ? ta : wdirq) !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask
  always @(posedge clk) begin
    if ((rv && rre) || (bv && bre)) begin
      samples_checked++;
      if (exq.size() == 0) fail("unexpected bus response");
      else if (((rv && rre) ? {rr, rd} : {br, 32'h0}) !== exq.pop_front()) fail("bus mismatch");
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdr(CT, 32'h0);
    repeat (20) @(posedge clk);
    rdr(`CWDT_OFF_COUNT, 32'h0);
    rdr(8'h40, 32'h0, `CWDT_RESP_SLVERR);
    wr(8'h44, 8'hFF, `CWDT_RESP_SLVERR);
    wr(`CWDT_OFF_IRQ_EN, 8'h03);
    for (int c = 0; c < 8; c++) begin
      p = 1 << (5 + c);
      wr(CT, 8'h80 | 8'(c << 3));
      wait_for(0, 5000, n);
      chk(n >= p - 3 && n <= p + 3, "period");
      svc(0);
      rdr(ST, 32'h1);
      chk(irq === 1'b1, "irq line");
      wr(CT, 8'h20);
      rdr(CT, {24'h0, 8'h81 | 8'(c << 3)});
      wr(CT, 8'h01);
      @(posedge clk);
      chk(wdirq === 1'b0, "flag clear");
      wr(CL, 8'h01);
      wr(CT, 8'h00);
      svc(0);
    end
    wr(CT, 8'h80);
    repeat (5) svc(1);
    chk(wdirq === 1'b0, "serviced");
    repeat (10) wr(SV, `CWDT_SVC_SECOND);
    chk(wdirq === 1'b1, "lone second write");
    svc(0);
    wr(CT, 8'h01);
    wr(CT, 8'hB8);
    repeat (60) @(posedge clk);
    chk(wdirq === 1'b0, "long period");
    wr(CT, 8'h80);
    wait_for(0, 4, n);
    chk(wdirq === 1'b1, "period cut");
    svc(0);
    wr(CT, 8'h01);
    wr(CT, 8'h84);
    wait_for(0, 100, n);
    wait_for(1, 100, n);
    chk(n >= 29 && n <= 35, "terminate delay");
    chk(wdirq === 1'b1, "request held");
    svc(0);
    rdr(CT, 32'h87);
    wr(CT, 8'h01);
    rdr(CT, 32'h86);
    wait_for(0, 100, n);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wait_for(1, 80, n);
    chk(n == 80, "acked yet terminated");
    svc(0);
    rdr(ST, 32'h3);
    wr(CL, 8'h01);
    rdr(ST, 32'h2);
    chk(irq === 1'b1, "irq terminate");
    wr(`CWDT_OFF_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "irq masked");
    svc(0);
    wr(CT, 8'h03);
    wr(CT, 8'h00);
    rdr(CT, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
